// File: src/tsa_top.sv
// Purpose: serial-bus target of a temperature sensor with limit alert
// Assumes: scl/sda/address pins asynchronous to clk_sys (250 MHz)
// Notes:   software writes conversion results over AHB-Lite
// Function
// - reads return data from the register the pointer selects
// - config write is pointer plus one byte into 8-bit config
// - limit write is pointer plus two bytes loading all 16 bits
// - config read answers with its single byte in every data byte
// - temperature read returns msb first then lsb
// - after reset alert is overtemperature mode, comparator behaviour
// - comparator: alert active while temperature at or above upper limit
// - comparator: alert inactive once temperature below hysteresis limit
// - shutdown leaves comparator alert state unchanged
// - interrupt: alert after configured consecutive over-limit conversions
// - interrupt: any register read clears active alert
// - interrupt: re-assert on any later over-limit conversion once fault count is met
// - config bit 2 selects alert polarity, 0 active low
// - config bit 1 selects comparator (0) or interrupt (1)
// - config bits 4:3 set fault count 1, 2, 4, 6
// - address is 1001 plus three sampled address-select pins
`timescale 1ns/1ps
module tsa_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // serial link
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_select_bit2,
  input  wire logic        addr_select_bit1,
  input  wire logic        addr_select_bit0,
  output logic             overtemp_alert_output,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // interrupt
  output logic             irq
);
  import tsa_pkg::*;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic             scl_prev_q;
  logic             sda_prev_q;
  assign pin_raw = {addr_select_bit2, addr_select_bit1, addr_select_bit0, sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= sync_q[0];
      sda_prev_q <= sync_q[1];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic [6:0] own_addr;
  assign scl_s     = sync_q[0];
  assign sda_s     = sync_q[1];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign own_addr  = {TSA_ADDR_HI, sync_q[4:2]};

  // ***************************************************************
  // registers of the sensor
  // ***************************************************************
  logic [7:0]  cfg_q;
  logic [15:0] hyst_q, ulim_q, temp_q;
  logic [7:0]  ptr_q;

  // a pointer value outside the map reads as the temperature
  function automatic logic [15:0] sel_reg(input logic [7:0] p, input logic [15:0] t,
                                          input logic [7:0] c, input logic [15:0] h,
                                          input logic [15:0] o);
    unique case (p)
      TSA_PTR_CFG:  sel_reg = {c, c};
      TSA_PTR_HYST: sel_reg = h;
      TSA_PTR_ULIM: sel_reg = o;
      default:      sel_reg = t;
    endcase
  endfunction

  function automatic logic [2:0] fault_need(input logic [1:0] fq);
    unique case (fq)
      2'b00: fault_need = TSA_FQ_1;
      2'b01: fault_need = TSA_FQ_2;
      2'b10: fault_need = TSA_FQ_4;
      2'b11: fault_need = TSA_FQ_6;
    endcase
  endfunction

  // ***************************************************************
  // serial target engine
  // ***************************************************************
  tsa_state_type st_q;
  logic [3:0]    bit_q;
  logic [7:0]    sh_q;
  logic [7:0]    tx_q;
  logic [1:0]    idx_q;
  logic          more_q;
  logic [7:0]    msb_q;
  logic          byte_in, wr_byte, rd_load, rd_clear;
  logic [15:0]   cur_reg;
  logic [7:0]    next_tx;

  assign cur_reg  = sel_reg(ptr_q, temp_q, cfg_q, hyst_q, ulim_q);
  assign byte_in  = scl_fall && (bit_q == TSA_BITS_BYTE);
  assign wr_byte  = byte_in && (st_q == TSA_WR);
  // bytes at index 0 (first, then every fourth after the 2-bit index wraps) msb, others lsb; config repeats its single byte
  assign next_tx  = (idx_q == 2'd0) ? cur_reg[15:8] : cur_reg[7:0];
  assign rd_load  = scl_fall && (((st_q == TSA_ADDR_ACK) && sh_q[0]) ||
                                 ((st_q == TSA_RD_ACK) && more_q));
  assign rd_clear = scl_fall && (st_q == TSA_ADDR_ACK) && sh_q[0];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= TSA_IDLE;
      bit_q  <= '0;
      sh_q   <= '0;
      tx_q   <= '0;
      idx_q  <= '0;
      more_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      st_q   <= TSA_ADDR;
      bit_q  <= '0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      st_q   <= TSA_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (st_q)
        TSA_IDLE: begin
          sda_oe <= 1'b0;
        end
        TSA_ADDR, TSA_WR: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'd1;
          end else if (byte_in) begin
            if (st_q == TSA_WR) begin
              sda_oe <= 1'b1;
              st_q   <= TSA_WR_ACK;
              // index parks at its top so bytes past the limit lsb are ignored
              if (idx_q != 2'd3) begin
                idx_q <= idx_q + 2'd1;
              end
            end else if (sh_q[7:1] == own_addr) begin
              sda_oe <= 1'b1;
              idx_q  <= '0;
              st_q   <= TSA_ADDR_ACK;
            end else begin
              st_q <= TSA_IDLE;
            end
          end
        end
        TSA_ADDR_ACK, TSA_WR_ACK: begin
          if (scl_fall) begin
            bit_q <= '0;
            if (rd_load) begin
              tx_q   <= next_tx;
              sda_oe <= ~next_tx[7];
              st_q   <= TSA_RD;
            end else begin
              sda_oe <= 1'b0;
              st_q   <= TSA_WR;
            end
          end
        end
        TSA_RD: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'd1;
          end else if (byte_in) begin
            sda_oe <= 1'b0;
            idx_q  <= idx_q + 2'd1;
            st_q   <= TSA_RD_ACK;
          end else if (scl_fall) begin
            tx_q   <= {tx_q[6:0], 1'b0};
            sda_oe <= ~tx_q[6];
          end
        end
        TSA_RD_ACK: begin
          if (scl_rise) begin
            more_q <= ~sda_s;
          end else if (rd_load) begin
            bit_q  <= '0;
            tx_q   <= next_tx;
            sda_oe <= ~next_tx[7];
            st_q   <= TSA_RD;
          end else if (scl_fall) begin
            st_q <= TSA_IDLE;
          end
        end
      endcase
    end
  end

  assign sda_o = 1'b0;

  // write bytes: pointer, then data for the selected register
  logic ev_ptr, ev_cfg, ev_lim;
  assign ev_ptr = wr_byte && (idx_q == 2'd0);
  assign ev_cfg = wr_byte && (idx_q == 2'd1) && (ptr_q == TSA_PTR_CFG);
  assign ev_lim = wr_byte && (idx_q == 2'd2) &&
                  ((ptr_q == TSA_PTR_ULIM) || (ptr_q == TSA_PTR_HYST));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q  <= TSA_PTR_TEMP;
      cfg_q  <= TSA_RST_CFG;
      hyst_q <= TSA_RST_HYST;
      ulim_q <= TSA_RST_ULIM;
      msb_q  <= '0;
    end else if (st_q == TSA_WR && scl_fall && bit_q == TSA_BITS_BYTE) begin
      if (ev_ptr) begin
        ptr_q <= sh_q;
      end
      if (ev_cfg) begin
        cfg_q <= sh_q;
      end
      if (idx_q == 2'd1) begin
        msb_q <= sh_q;
      end
      if (ev_lim && ptr_q == TSA_PTR_ULIM) begin
        ulim_q <= {msb_q, sh_q};
      end
      if (ev_lim && ptr_q == TSA_PTR_HYST) begin
        hyst_q <= {msb_q, sh_q};
      end
    end
  end

  // ***************************************************************
  // alert logic
  // ***************************************************************
  logic       conv_q;
  logic [2:0] fault_q;
  logic       active_q;
  logic       over, below_hyst, hit;
  logic [2:0] fault_d;
  // signed compares so negative limits and readings order correctly
  assign over       = $signed(temp_q) >= $signed(ulim_q);
  assign below_hyst = $signed(temp_q) < $signed(hyst_q);
  assign fault_d    = !over ? 3'd0 :
                      (fault_q == TSA_FQ_6) ? fault_q : fault_q + 3'd1;
  assign hit        = conv_q && over && (fault_d >= fault_need(cfg_q[TSA_CFG_FQ+:2]));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fault_q <= '0;
    end else if (conv_q) begin
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= 1'b0;
    end else if (!cfg_q[TSA_CFG_INT]) begin
      if (hit) begin
        active_q <= 1'b1;
      end else if (conv_q && below_hyst) begin
        active_q <= 1'b0;
      end
    end else if (hit) begin
      active_q <= 1'b1;
    end else if (rd_clear) begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      overtemp_alert_output <= 1'b1;
    end else begin
      overtemp_alert_output <= cfg_q[TSA_CFG_POL] ? active_q : ~active_q;
    end
  end

  // ***************************************************************
  // ahb-lite slave, zero wait states
  // ***************************************************************
  logic       dp_wr_q;
  logic [7:0] dp_addr_q;
  logic       ap_take;
  logic [TSA_NEV-1:0] stat_q, en_q, ev, clr;
  assign ap_take = hsel && hready && htrans[1];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr_q   <= ap_take && hwrite;
      dp_addr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_take && !hwrite) begin
        unique case (haddr[7:0])
          TSA_REG_TEMP: hrdata <= {16'h0000, temp_q};
          TSA_REG_STAT: hrdata <= {27'h000_0000, stat_q};
          TSA_REG_EN:   hrdata <= {27'h000_0000, en_q};
          TSA_REG_INFO: hrdata <= {15'h0000, active_q, ptr_q, cfg_q};
          default:      hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // a write of the temperature register stands in for a finished conversion;
  // in shutdown it is stored but not judged, so the alert holds its state unless an interrupt-mode read clears it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      temp_q <= TSA_RST_TEMP;
      conv_q <= 1'b0;
      en_q   <= '0;
    end else begin
      conv_q <= 1'b0;
      if (dp_wr_q && dp_addr_q == TSA_REG_TEMP) begin
        temp_q <= hwdata[15:0];
        conv_q <= ~cfg_q[TSA_CFG_SHDN];
      end
      if (dp_wr_q && dp_addr_q == TSA_REG_EN) begin
        en_q <= hwdata[TSA_NEV-1:0];
      end
    end
  end

  assign clr = (dp_wr_q && dp_addr_q == TSA_REG_CLR) ? hwdata[TSA_NEV-1:0] : '0;
  always_comb begin
    ev               = '0;
    ev[TSA_EV_CFG]   = ev_cfg;
    ev[TSA_EV_LIM]   = ev_lim;
    ev[TSA_EV_RD]    = rd_clear;
    ev[TSA_EV_ALERT] = hit && !active_q;
    ev[TSA_EV_PTR]   = ev_ptr;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
      irq    <= |(stat_q & en_q);
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_addr_ack;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_q == TSA_ADDR && byte_in && sh_q[7:1] == own_addr) |=> sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack on own address");

  property p_cfg_store;
    @(posedge clk_sys) disable iff (sys_rst)
      ev_cfg |=> (cfg_q == $past(sh_q));
  endproperty
  a_cfg_store: assert property (p_cfg_store) else $error("config byte not stored");

  property p_ulim_store;
    @(posedge clk_sys) disable iff (sys_rst)
      (ev_lim && ptr_q == TSA_PTR_ULIM) |=> (ulim_q == {$past(msb_q), $past(sh_q)});
  endproperty
  a_ulim_store: assert property (p_ulim_store) else $error("upper limit not loaded");

  property p_cmp_set;
    @(posedge clk_sys) disable iff (sys_rst)
      (!cfg_q[TSA_CFG_INT] && hit) |=> active_q ##1 (overtemp_alert_output == cfg_q[TSA_CFG_POL]);
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("comparator alert not set");

  property p_cmp_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      (!cfg_q[TSA_CFG_INT] && conv_q && !hit && below_hyst) |=> !active_q;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("comparator alert not cleared");

  property p_shdn_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (cfg_q[TSA_CFG_SHDN] && !cfg_q[TSA_CFG_INT] && !rd_clear) |=> $stable(active_q);
  endproperty
  a_shdn_hold: assert property (p_shdn_hold) else $error("shutdown changed alert");

  property p_int_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      (cfg_q[TSA_CFG_INT] && rd_clear && !hit) |=> !active_q;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("read did not clear alert");

  property p_fault_reset;
    @(posedge clk_sys) disable iff (sys_rst)
      (conv_q && !over) |=> (fault_q == 3'd0) && !$rose(active_q);
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault count not cleared");

  property p_msb_first;
    @(posedge clk_sys) disable iff (sys_rst)
      (rd_load && idx_q == 2'd0 && ptr_q == TSA_PTR_TEMP) |=> (tx_q == temp_q[15:8]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("temperature msb not first");

  c_cmp_alert: cover property (@(posedge clk_sys) disable iff (sys_rst)
    !cfg_q[TSA_CFG_INT] && $rose(active_q));
  c_int_clear: cover property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_q[TSA_CFG_INT] && $fell(active_q));
  c_temp_read: cover property (@(posedge clk_sys) disable iff (sys_rst)
    rd_load && ptr_q == TSA_PTR_TEMP);
endmodule

// File: src/tsa_pkg.sv
// Purpose: shared constants of the temperature sensor target block
// Assumes: one system clock; serial link sampled, not clocked
// Notes:   register byte offsets are for the AHB-Lite control port
package tsa_pkg;
  // ***************************************************************
  // serial side
  // ***************************************************************
  localparam logic [3:0]  TSA_ADDR_HI   = 4'h9;
  localparam logic [7:0]  TSA_PTR_TEMP  = 8'h00;
  localparam logic [7:0]  TSA_PTR_CFG   = 8'h01;
  localparam logic [7:0]  TSA_PTR_HYST  = 8'h02;
  localparam logic [7:0]  TSA_PTR_ULIM  = 8'h03;
  localparam logic [7:0]  TSA_RST_CFG   = 8'h00;
  localparam logic [15:0] TSA_RST_HYST  = 16'h4B00;
  localparam logic [15:0] TSA_RST_ULIM  = 16'h5000;
  localparam logic [15:0] TSA_RST_TEMP  = 16'h0000;
  localparam int          TSA_CFG_SHDN  = 0;
  localparam int          TSA_CFG_INT   = 1;
  localparam int          TSA_CFG_POL   = 2;
  localparam int          TSA_CFG_FQ    = 3;
  localparam logic [3:0]  TSA_BITS_BYTE = 4'h8;
  localparam logic [2:0]  TSA_FQ_1      = 3'h1;
  localparam logic [2:0]  TSA_FQ_2      = 3'h2;
  localparam logic [2:0]  TSA_FQ_4      = 3'h4;
  localparam logic [2:0]  TSA_FQ_6      = 3'h6;
  // ***************************************************************
  // control port
  // ***************************************************************
  localparam logic [7:0]  TSA_REG_TEMP  = 8'h00;
  localparam logic [7:0]  TSA_REG_STAT  = 8'h04;
  localparam logic [7:0]  TSA_REG_CLR   = 8'h08;
  localparam logic [7:0]  TSA_REG_EN    = 8'h0C;
  localparam logic [7:0]  TSA_REG_INFO  = 8'h10;
  localparam int          TSA_NEV       = 5;
  localparam int          TSA_EV_CFG    = 0;
  localparam int          TSA_EV_LIM    = 1;
  localparam int          TSA_EV_RD     = 2;
  localparam int          TSA_EV_ALERT  = 3;
  localparam int          TSA_EV_PTR    = 4;

  typedef enum logic [2:0] {
    TSA_IDLE,
    TSA_ADDR,
    TSA_ADDR_ACK,
    TSA_WR,
    TSA_WR_ACK,
    TSA_RD,
    TSA_RD_ACK
  } tsa_state_type;
endpackage

// File: test/tsa_mst.sv
// Purpose: serial bus master model for the sensor link
// Assumes: data line pulled up; sda_drv low pulls it down
// Notes:   clock stands high between frames; lag stretches the low phase
`timescale 1ns/1ps
module tsa_mst (
  // link pins
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_in
);
  int lag = 0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ***************************************************************
  // bit level, 125 ns clock
  // ***************************************************************
  task automatic put(input logic b);
    #(20 + lag) sda_drv = b;
    #42.5 scl = 1'b1;
    #62.5 scl = 1'b0;
  endtask
  task automatic get(output logic b);
    #(20 + lag) sda_drv = 1'b1;
    #42.5 scl = 1'b1;
    #31 b = sda_in;
    #31.5 scl = 1'b0;
  endtask
  // ***************************************************************
  // one transaction: start, address, pointer, n bytes, stop
  // ***************************************************************
  task automatic frame(input logic [6:0] dev, input logic rd, input logic set_ptr,
                       input logic [7:0] ptr, input int n, inout logic [15:0] d,
                       output logic nak);
    logic       b;
    logic [7:0] by;
    #62.5 sda_drv = 1'b0;
    #62.5 scl = 1'b0;
    by = {dev, rd};
    for (int i = 7; i >= 0; i--) put(by[i]);
    get(nak);
    if (!nak && !rd && set_ptr) begin
      for (int i = 7; i >= 0; i--) put(ptr[i]);
      get(b);
    end
    for (int k = 0; k < n && !nak; k++) begin
      if (rd) begin
        for (int i = 7; i >= 0; i--) get(by[i]);
        d[15-8*k -: 8] = by;
        // the last byte is refused so the target lets go of the line
        put(k == n - 1);
      end else begin
        by = d[15-8*k -: 8];
        for (int i = 7; i >= 0; i--) put(by[i]);
        get(b);
      end
    end
    #(20 + lag) sda_drv = 1'b0;
    #42.5 scl = 1'b1;
    #62.5 sda_drv = 1'b1;
  endtask
endmodule

// File: test/tb_tsa_top.sv
// Purpose: self-checking bench for the temperature sensor target
// Assumes: one bus slave; the link master model drives clock and data
// Notes:   conversions arrive as writes to the temperature word
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_tsa_top;
  import tsa_pkg::*;
  logic        clk_sys;
  logic        sys_rst;
  logic        scl;
  logic        sda_drv;
  wire logic   sda_line;
  logic        sda_o;
  logic        sda_oe;
  logic        addr_select_bit2;
  logic        addr_select_bit1;
  logic        addr_select_bit0;
  logic        overtemp_alert_output;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        irq;
  int          n_errors = 0;
  int          comparisons = 0;
  // open drain: the line is low while either party pulls it
  assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
  assign hready = hreadyout;
  always #2 clk_sys = ~clk_sys;
  tsa_top tsa_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_bit2(addr_select_bit2),
    .addr_select_bit1(addr_select_bit1), .addr_select_bit0(addr_select_bit0),
    .overtemp_alert_output(overtemp_alert_output), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));
  tsa_mst tsa_mst_i (.scl(scl), .sda_drv(sda_drv), .sda_in(sda_line));
  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_rdy;
    int t;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (hready !== 1'b1 && t < 64);
    if (hready !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  function automatic logic [6:0] dev();
    return {TSA_ADDR_HI, addr_select_bit2, addr_select_bit1, addr_select_bit0};
  endfunction
  task automatic lw(input logic [7:0] p, input int n, input logic [15:0] v);
    logic nak;
    tsa_mst_i.frame(dev(), 1'b0, 1'b1, p, n, v, nak);
    `CHK("write ack", 1'b0, nak)
  endtask
  task automatic lr(input logic [7:0] p, input int n, output logic [15:0] v);
    logic nak;
    v = 16'h0000;
    tsa_mst_i.frame(dev(), 1'b0, 1'b1, p, 0, v, nak);
    tsa_mst_i.frame(dev(), 1'b1, 1'b0, p, n, v, nak);
    `CHK("read ack", 1'b0, nak)
  endtask
  task automatic conv_chk(input logic [15:0] t, input logic e);
    logic [31:0] r;
    ahb(1'b1, TSA_REG_TEMP, {16'h0000, t}, r);
    repeat (5) @(posedge clk_sys);
    `CHK("alert", e, overtemp_alert_output)
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset;
    logic [31:0] r;
    logic [15:0] d;
    `CHK("alert idle", 1'b1, overtemp_alert_output)
    ahb(1'b0, TSA_REG_INFO, 32'h0, r);
    `CHK("info", 32'h0, r)
    lr(TSA_PTR_ULIM, 2, d);
    `CHK("upper limit", TSA_RST_ULIM, d)
    lr(TSA_PTR_HYST, 2, d);
    `CHK("hysteresis", TSA_RST_HYST, d)
  endtask
  task automatic t_regs;
    logic [15:0] d;
    logic [31:0] r;
    lw(TSA_PTR_ULIM, 2, 16'h1900);
    lw(TSA_PTR_HYST, 2, 16'h1400);
    lr(TSA_PTR_ULIM, 2, d);
    `CHK("upper limit", 16'h1900, d)
    lr(TSA_PTR_HYST, 2, d);
    `CHK("hysteresis", 16'h1400, d)
    lw(TSA_PTR_CFG, 1, 16'h1800);
    lr(TSA_PTR_CFG, 1, d);
    `CHK("config", 8'h18, d[15:8])
    ahb(1'b0, TSA_REG_INFO, 32'h0, r);
    `CHK("info", 32'h0000_0118, r)
    lw(TSA_PTR_CFG, 1, 16'h0000);
  endtask
  task automatic t_temp;
    logic [15:0] d;
    tsa_mst_i.lag = 200;
    conv_chk(16'h1234, 1'b1);
    lr(TSA_PTR_TEMP, 2, d);
    `CHK("temperature", 16'h1234, d)
    tsa_mst_i.lag = 0;
  endtask
  task automatic t_addr;
    logic [15:0] d;
    logic        nak;
    @(posedge clk_sys);
    {addr_select_bit2, addr_select_bit1, addr_select_bit0} <= 3'b101;
    repeat (4) @(posedge clk_sys);
    tsa_mst_i.frame({TSA_ADDR_HI, 3'b000}, 1'b0, 1'b1, TSA_PTR_CFG, 0, d, nak);
    `CHK("old address", 1'b1, nak)
    lr(TSA_PTR_ULIM, 2, d);
    `CHK("new address", 16'h1900, d)
  endtask
  task automatic t_cmp;
    conv_chk(16'h18F0, 1'b1);
    conv_chk(16'hE000, 1'b1);
    conv_chk(16'h1900, 1'b0);
    conv_chk(16'h1500, 1'b0);
    lw(TSA_PTR_CFG, 1, 16'h0100);
    conv_chk(16'h1000, 1'b0);
    lw(TSA_PTR_CFG, 1, 16'h0000);
    conv_chk(16'h13F0, 1'b1);
  endtask
  task automatic t_int;
    int          cnt[4] = '{1, 2, 4, 6};
    logic [15:0] d;
    for (int c = 0; c < 4; c++) begin
      lw(TSA_PTR_CFG, 1, {3'b000, c[1:0], 3'b110, 8'h00});
      conv_chk(16'h1000, 1'b0);
      for (int k = 1; k < cnt[c]; k++) conv_chk(16'h1900, 1'b0);
      conv_chk(16'h2000, 1'b1);
      lr(TSA_PTR_TEMP, 2, d);
      `CHK("alert cleared", 1'b0, overtemp_alert_output)
    end
    lw(TSA_PTR_CFG, 1, 16'h0600);
    conv_chk(16'h1000, 1'b0);
    conv_chk(16'h1900, 1'b1);
    lr(TSA_PTR_CFG, 2, d);
    `CHK("alert cleared", 1'b0, overtemp_alert_output)
  endtask
  task automatic t_irq;
    logic [31:0] r;
    lw(TSA_PTR_CFG, 1, 16'h0000);
    conv_chk(16'h1000, 1'b1);
    ahb(1'b0, TSA_REG_STAT, 32'h0, r);
    `CHK("status events", 32'h0000_001F, r)
    ahb(1'b1, TSA_REG_CLR, 32'h0000_001F, r);
    ahb(1'b1, TSA_REG_STAT, 32'h0000_001F, r);
    ahb(1'b0, TSA_REG_STAT, 32'h0, r);
    `CHK("status cleared", 32'h0, r)
    ahb(1'b1, TSA_REG_EN, 32'h0000_0008, r);
    conv_chk(16'h2000, 1'b0);
    `CHK("irq raised", 1'b1, irq)
    ahb(1'b1, TSA_REG_EN, 32'h0, r);
    ahb(1'b0, TSA_REG_STAT, 32'h0, r);
    `CHK("status sticky", 32'h0000_0008, r)
    `CHK("irq masked", 1'b0, irq)
    ahb(1'b1, TSA_REG_EN, 32'h0000_0008, r);
    ahb(1'b0, TSA_REG_EN, 32'h0, r);
    `CHK("enable", 32'h0000_0008, r)
    `CHK("irq unmasked", 1'b1, irq)
    ahb(1'b1, TSA_REG_CLR, 32'h0000_0008, r);
    ahb(1'b0, 8'h20, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    `CHK("irq cleared", 1'b0, irq)
  endtask
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {addr_select_bit2, addr_select_bit1, addr_select_bit0} = 3'b000;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_regs();
    t_temp();
    t_addr();
    t_cmp();
    t_int();
    t_irq();
    give_verdict();
  end
endmodule
